// >>> core/mrb_consts.svh
// constants for the multi-picture reference buffer manager
// assumes inclusion by bare name from the core design files
`ifndef MRB_CONSTS_SVH
`define MRB_CONSTS_SVH

// ************************************************************
// sizes
// ************************************************************
`define MRB_ENTRIES 8
`define MRB_IDX_W 3
`define MRB_SERIAL_W 10
`define MRB_SLOT_W 4
`define MRB_LIMIT_W 5
`define MRB_SERIAL_STEP 10'h001
`define MRB_LIMIT_RESET 5'h00
`define MRB_SERIAL_RESET 10'h000

// ************************************************************
// backward set sizes for B pictures
// ************************************************************
`define MRB_BWD_ONE 4'h1
`define MRB_BWD_TWO 4'h2

// ************************************************************
// picture reference code lengths
// ************************************************************
`define MRB_LEN_1 3'h1
`define MRB_LEN_3 3'h3
`define MRB_LEN_5 3'h5

`endif

// >>> core/mrb_pkg.sv
// types shared by the reference buffer manager
// assumes mrb_consts.svh is on the include path
`include "mrb_consts.svh"

package mrb_pkg;

    typedef logic [`MRB_SERIAL_W-1:0] mrb_serial_t;
    typedef logic [`MRB_SLOT_W-1:0] mrb_slot_t;

    typedef enum logic [1:0] {
        MRB_FREE,
        MRB_SHORT,
        MRB_LONG
    } mrb_kind_e;

    typedef struct packed {
        mrb_kind_e kind;
        mrb_serial_t serial;
        mrb_slot_t slot;
    } mrb_entry_s;

endpackage : mrb_pkg

// >>> core/mrb_ref_buffer.sv
// reference buffer manager: picture serials, long-term slots,
// default index order and macroblock reference field handling
// assumes one clock and a parser that presents one event per cycle
`include "mrb_consts.svh"

// How it works
// - forward index field expected with forward motion data; relative into forward set
// - forward guard bit exactly when index decodes to one without unrestricted vectors
// - backward select bit only in B pictures with backward data and two-picture mode
// - select 0 uses first backward reference, 1 uses the second
// - backward guard bit when select 0, no unrestricted vectors, five zero bits before
// - buffer follows every control operation, even on damaged pictures
// - serial kept modulo 1024, first picture expected to carry zero; any first serial after mode start is taken without a loss check
// - serial step other than one flags picture loss
// - new picture gets default index 0; other indices shift
// - stored picture enters short-term; long-term only by assignment
// - slot limit is zero when selection mode starts
// - slot limit holds until a new value arrives
// - new limit frees long-term pictures with slot at or above it
// - control operation converts the delta-named short-term picture to a slot
// - earlier occupant of the target slot is freed
// - slot above limit minus one raises an error
// - repeat of an existing assignment leaves the buffer unchanged
// - picture already in another slot raises an error
// - two-picture mode: first two indices backward, the rest forward
module mrb_ref_buffer
    import mrb_pkg::*;
(
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic multi_ref_selection_mode_start_in,
    input wire logic store_in,
    input wire logic [`MRB_SERIAL_W-1:0] picture_serial_in,
    input wire logic limit_in,
    input wire logic [`MRB_LIMIT_W-1:0] long_term_slot_limit_in,
    input wire logic buffer_control_op_in,
    input wire logic [`MRB_SERIAL_W-1:0] picture_serial_delta_in,
    input wire logic [`MRB_SLOT_W-1:0] long_term_slot_in,
    input wire logic mb_in,
    input wire logic b_picture_in,
    input wire logic fwd_mv_data_in,
    input wire logic backward_mv_data_in,
    input wire logic two_pic_bwd_in,
    input wire logic umv_mode_in,
    input wire logic prior_five_zero_in,
    input wire logic [4:0] fwd_code_in,
    input wire logic [2:0] fwd_code_len_in,
    input wire logic backward_ref_select_in,
    output logic forward_ref_present_out,
    output logic [3:0] forward_ref_index_out,
    output logic fwd_emul_guard_bit_out,
    output logic bwd_select_present_out,
    output logic bwd_emul_guard_bit_out,
    output logic fwd_hit_out,
    output logic [`MRB_SERIAL_W-1:0] fwd_serial_out,
    output logic fwd_long_out,
    output logic bwd_hit_out,
    output logic [`MRB_SERIAL_W-1:0] bwd_serial_out,
    output logic loss_out,
    output logic err_range_out,
    output logic err_dup_out,
    output logic err_missing_out,
    output logic [`MRB_LIMIT_W-1:0] limit_out,
    output logic [3:0] count_out
);

    // ************************************************************
    // functions
    // ************************************************************
    // code 1 -> 0, 0x0 -> 1+x, 0x0y0 -> 3+xy
    function automatic logic [3:0] ref_decode(input logic [4:0] code, input logic [2:0] len);
        logic [3:0] v;
        v = 4'h0;
        if (len == `MRB_LEN_3) begin
            v = 4'h1 + {3'h0, code[1]};
        end else if (len == `MRB_LEN_5) begin
            v = 4'h3 + {2'h0, code[3], code[1]};
        end
        return v;
    endfunction : ref_decode

    // ************************************************************
    // storage
    // ************************************************************
    mrb_entry_s buf_q [`MRB_ENTRIES];
    logic [`MRB_LIMIT_W-1:0] limit;
    mrb_serial_t last_serial;
    logic have_last;
    // default index: short by recency, then long by slot
    logic [10:0] key [`MRB_ENTRIES];
    logic [3:0] nvalid, rank [`MRB_ENTRIES];
    always_comb begin
        for (int i = 0; i < `MRB_ENTRIES; i++) begin
            if (buf_q[i].kind == MRB_LONG) begin
                key[i] = {1'b1, 6'h00, buf_q[i].slot};
            end else begin
                key[i] = {1'b0, last_serial - buf_q[i].serial};
            end
        end
        nvalid = 4'h0;
        for (int i = 0; i < `MRB_ENTRIES; i++) begin
            rank[i] = 4'h0;
            if (buf_q[i].kind != MRB_FREE) begin
                nvalid = nvalid + 4'h1;
            end
            for (int j = 0; j < `MRB_ENTRIES; j++) begin
                if (buf_q[j].kind != MRB_FREE && key[j] < key[i]) begin
                    rank[i] = rank[i] + 4'h1;
                end
            end
        end
    end

    // ************************************************************
    // assignment lookup
    // ************************************************************
    mrb_serial_t target;
    mrb_slot_t tgt_slot;
    logic tgt_found, tgt_long, slot_bad, free_found;
    logic [`MRB_IDX_W-1:0] tgt_idx, free_idx, oldest_idx;
    always_comb begin
        target = last_serial - picture_serial_delta_in;
        tgt_found = 1'b0;
        tgt_long = 1'b0;
        tgt_slot = '0;
        tgt_idx = '0;
        free_found = 1'b0;
        free_idx = '0;
        oldest_idx = '0;
        for (int i = 0; i < `MRB_ENTRIES; i++) begin
            if (buf_q[i].kind != MRB_FREE && buf_q[i].serial == target) begin
                tgt_found = 1'b1;
                tgt_long = buf_q[i].kind == MRB_LONG;
                tgt_slot = buf_q[i].slot;
                tgt_idx = i[`MRB_IDX_W-1:0];
            end
            if (buf_q[i].kind == MRB_FREE && !free_found) begin
                free_found = 1'b1;
                free_idx = i[`MRB_IDX_W-1:0];
            end
            if (buf_q[i].kind == MRB_SHORT
                && (buf_q[oldest_idx].kind != MRB_SHORT || key[i] >= key[oldest_idx])) begin
                oldest_idx = i[`MRB_IDX_W-1:0];
            end
        end
        slot_bad = {1'b0, long_term_slot_in} >= limit;
    end

    // ************************************************************
    // buffer update
    // ************************************************************
    // one event per cycle; mode start outranks the others
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < `MRB_ENTRIES; i++) begin
                buf_q[i] <= '{MRB_FREE, '0, '0};
            end
        end else if (multi_ref_selection_mode_start_in) begin
            for (int i = 0; i < `MRB_ENTRIES; i++) begin
                buf_q[i].kind <= MRB_FREE;
            end
        end else if (limit_in) begin
            for (int i = 0; i < `MRB_ENTRIES; i++) begin
                if (buf_q[i].kind == MRB_LONG
                    && {1'b0, buf_q[i].slot} >= long_term_slot_limit_in) begin
                    buf_q[i].kind <= MRB_FREE;
                end
            end
        end else if (buffer_control_op_in) begin
            // damaged pictures still apply the operation
            if (tgt_found && !tgt_long && !slot_bad) begin
                for (int i = 0; i < `MRB_ENTRIES; i++) begin
                    if (buf_q[i].kind == MRB_LONG && buf_q[i].slot == long_term_slot_in) begin
                        buf_q[i].kind <= MRB_FREE;
                    end
                end
                buf_q[tgt_idx].kind <= MRB_LONG;
                buf_q[tgt_idx].slot <= long_term_slot_in;
            end
            // same slot repeat needs no action
        end else if (store_in) begin
            // full buffer: oldest short-term picture gives way
            if (free_found) begin
                buf_q[free_idx] <= '{MRB_SHORT, picture_serial_in, '0};
            end else begin
                buf_q[oldest_idx] <= '{MRB_SHORT, picture_serial_in, '0};
            end
        end
    end

    // newest serial becomes key 0, so default index 0
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            last_serial <= `MRB_SERIAL_RESET;
            have_last <= 1'b0;
        end else if (multi_ref_selection_mode_start_in) begin
            have_last <= 1'b0;
        end else if (!limit_in && !buffer_control_op_in && store_in) begin
            last_serial <= picture_serial_in;
            have_last <= 1'b1;
        end
    end
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            limit <= `MRB_LIMIT_RESET;
        end else if (multi_ref_selection_mode_start_in) begin
            limit <= `MRB_LIMIT_RESET;
        end else if (limit_in) begin
            limit <= long_term_slot_limit_in;
        end
    end

    // ************************************************************
    // error and loss reporting
    // ************************************************************
    logic store_ev, ctrl_ev;
    assign store_ev = store_in && !multi_ref_selection_mode_start_in && !limit_in
        && !buffer_control_op_in;
    assign ctrl_ev = buffer_control_op_in && !multi_ref_selection_mode_start_in && !limit_in;

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            loss_out <= 1'b0;
            err_range_out <= 1'b0;
            err_dup_out <= 1'b0;
            err_missing_out <= 1'b0;
        end else begin
            // gap in serials means a lost or corrupt picture
            loss_out <= store_ev && have_last
                && (picture_serial_in - last_serial) != `MRB_SERIAL_STEP;
            err_range_out <= ctrl_ev && slot_bad;
            err_dup_out <= ctrl_ev && !slot_bad && tgt_found && tgt_long
                && tgt_slot != long_term_slot_in;
            err_missing_out <= ctrl_ev && !slot_bad && !tgt_found;
        end
    end
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            limit_out <= `MRB_LIMIT_RESET;
            count_out <= 4'h0;
        end else begin
            limit_out <= limit;
            count_out <= nvalid;
        end
    end

    // ************************************************************
    // macroblock reference fields
    // ************************************************************
    logic [3:0] fwd_idx, bwd_count, fwd_rank, bwd_rank;
    logic bsel_here, fhit, bhit, flong;
    mrb_serial_t fser, bser;
    always_comb begin
        fwd_idx = ref_decode(fwd_code_in, fwd_code_len_in);
        bwd_count = 4'h0;
        if (b_picture_in) begin
            bwd_count = two_pic_bwd_in ? `MRB_BWD_TWO : `MRB_BWD_ONE;
        end
        bsel_here = b_picture_in && backward_mv_data_in && two_pic_bwd_in;
        fwd_rank = fwd_idx + bwd_count;
        bwd_rank = {3'h0, bsel_here && backward_ref_select_in};
        fhit = 1'b0;
        bhit = 1'b0;
        fser = '0;
        bser = '0;
        flong = 1'b0;
        for (int i = 0; i < `MRB_ENTRIES; i++) begin
            if (buf_q[i].kind != MRB_FREE && rank[i] == fwd_rank) begin
                fhit = 1'b1;
                fser = buf_q[i].serial;
                flong = buf_q[i].kind == MRB_LONG;
            end
            if (buf_q[i].kind != MRB_FREE && rank[i] == bwd_rank) begin
                bhit = b_picture_in;
                bser = buf_q[i].serial;
            end
        end
    end

    // fields hold their value between macroblocks
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            forward_ref_present_out <= 1'b0;
            forward_ref_index_out <= 4'h0;
            fwd_emul_guard_bit_out <= 1'b0;
            bwd_select_present_out <= 1'b0;
            bwd_emul_guard_bit_out <= 1'b0;
            fwd_hit_out <= 1'b0;
            fwd_serial_out <= '0;
            fwd_long_out <= 1'b0;
            bwd_hit_out <= 1'b0;
            bwd_serial_out <= '0;
        end else if (mb_in) begin
            forward_ref_present_out <= fwd_mv_data_in;
            forward_ref_index_out <= fwd_mv_data_in ? fwd_idx : 4'h0;
            fwd_emul_guard_bit_out <= fwd_mv_data_in && fwd_idx == 4'h1
                && !umv_mode_in;
            bwd_select_present_out <= bsel_here;
            bwd_emul_guard_bit_out <= bsel_here && !backward_ref_select_in
                && !umv_mode_in && prior_five_zero_in;
            fwd_hit_out <= fwd_mv_data_in && fhit;
            fwd_serial_out <= fser;
            fwd_long_out <= flong;
            bwd_hit_out <= backward_mv_data_in && bhit;
            bwd_serial_out <= bser;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_fwd_guard;
        @(posedge mclk_in) disable iff (sys_rst_in)
        mb_in && fwd_mv_data_in && !umv_mode_in && fwd_code_len_in == `MRB_LEN_3
            && fwd_code_in[2:0] == 3'h0 |=> fwd_emul_guard_bit_out;
    endproperty
    a_fwd_guard: assert property (p_fwd_guard) else $error("forward guard missing");
    property p_bsel;
        @(posedge mclk_in) disable iff (sys_rst_in)
        mb_in && !b_picture_in |=> !bwd_select_present_out && !bwd_emul_guard_bit_out;
    endproperty
    a_bsel: assert property (p_bsel) else $error("backward select outside B");
    property p_bwd_guard;
        @(posedge mclk_in) disable iff (sys_rst_in)
        mb_in && umv_mode_in |=> !bwd_emul_guard_bit_out && !fwd_emul_guard_bit_out;
    endproperty
    a_bwd_guard: assert property (p_bwd_guard) else $error("guard under umv");
    property p_loss;
        @(posedge mclk_in) disable iff (sys_rst_in)
        store_ev && have_last && picture_serial_in == last_serial + `MRB_SERIAL_STEP
            |=> !loss_out;
    endproperty
    a_loss: assert property (p_loss) else $error("false loss report");
    property p_limit_start;
        @(posedge mclk_in) disable iff (sys_rst_in)
        multi_ref_selection_mode_start_in |=> ##1 limit_out == `MRB_LIMIT_RESET;
    endproperty
    a_limit_start: assert property (p_limit_start) else $error("limit not zero");
    property p_limit_hold;
        @(posedge mclk_in) disable iff (sys_rst_in)
        !limit_in && !multi_ref_selection_mode_start_in |=> $stable(limit);
    endproperty
    a_limit_hold: assert property (p_limit_hold) else $error("limit drifted");
    property p_range;
        @(posedge mclk_in) disable iff (sys_rst_in)
        ctrl_ev && slot_bad |=> err_range_out && !err_dup_out && !err_missing_out;
    endproperty
    a_range: assert property (p_range) else $error("range error missed");
    // count_out trails the buffer by one more cycle than the error pulses
    property p_repeat;
        @(posedge mclk_in) disable iff (sys_rst_in)
        ctrl_ev && !slot_bad && tgt_found && tgt_long && tgt_slot == long_term_slot_in
            |=> (!err_dup_out && !err_missing_out) ##1 $stable(count_out);
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat changed buffer");
    property p_convert;
        @(posedge mclk_in) disable iff (sys_rst_in)
        ctrl_ev && !slot_bad && tgt_found && !tgt_long
            |=> buf_q[$past(tgt_idx)].kind == MRB_LONG;
    endproperty
    a_convert: assert property (p_convert) else $error("conversion missed");

endmodule : mrb_ref_buffer

// >>> sim/mrb_parser_model.sv
// parser model: hands decoded events and macroblock fields to the buffer
// assumes the bench calls its tasks from one process, one call at a time
module mrb_parser_model
    import mrb_pkg::*;
(
    input wire logic mclk_in,
    output logic mode_start_out,
    output logic store_out,
    output mrb_serial_t serial_out,
    output logic limit_out,
    output logic [4:0] limit_val_out,
    output logic ctrl_out,
    output mrb_serial_t delta_out,
    output mrb_slot_t slot_out,
    output logic mb_out,
    output logic [6:0] mb_bits_out,
    output logic [4:0] code_out,
    output logic [2:0] len_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // idle values
    // ************************************************************
    initial begin
        {mode_start_out, store_out, limit_out, ctrl_out, mb_out} = 5'h00;
        {serial_out, delta_out, limit_val_out, slot_out} = 29'h0;
        {mb_bits_out, code_out, len_out} = 15'h0;
    end

    // ************************************************************
    // one event, k: 0 mode start, 1 store, 2 limit, 3 control
    // ************************************************************
    // serials come from the bench in encoder order
    // a slot beyond the limit is sent only on purpose
    task automatic pulse(input int k, input logic [9:0] a, input logic [4:0] b);
        @(negedge mclk_in);
        {mode_start_out, store_out, limit_out, ctrl_out} = 4'h8 >> k;
        serial_out = a;
        delta_out = a;
        limit_val_out = b;
        slot_out = b[3:0];
        @(negedge mclk_in);
        {mode_start_out, store_out, limit_out, ctrl_out} = 4'h0;
        // released lines must not keep their last value
        serial_out = ~a;
        delta_out = ~a;
        limit_val_out = ~b;
        slot_out = ~b[3:0];
        repeat (2) @(negedge mclk_in);
    endtask : pulse

    // ************************************************************
    // one macroblock: f = b, fwd, bwd, two, umv, five zeros, select
    // ************************************************************
    // select is driven even where absent
    task automatic mb_evt(input logic [6:0] f, input logic [4:0] c, input logic [2:0] l);
        @(negedge mclk_in);
        mb_out = 1'b1;
        mb_bits_out = f;
        code_out = c;
        len_out = l;
        @(negedge mclk_in);
        mb_out = 1'b0;
        mb_bits_out = ~f;
        code_out = ~c;
        repeat (2) @(negedge mclk_in);
    endtask : mb_evt
endmodule : mrb_parser_model

// >>> sim/multi_picture_ref_buffer_mgr_bench.sv
// bench for the reference buffer manager
// assumes the parser model drives every input of the design except clock and reset
module multi_picture_ref_buffer_mgr_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ms, st, li, co, mb, fp, fg, bp, bg, fh, fl, bh, loss, er, ed, em;
    logic [9:0] ser, dl, fs, bs;
    logic [4:0] lv, code, lim;
    logic [3:0] sl, fi, cnt;
    logic [6:0] f;
    logic [2:0] len;
    logic [1:0] mb_pipe = 2'h0;
    logic [3:0] evq[$];
    logic [31:0] mbq[$];
    int err_count = 0;
    int n_tests = 0;
    int seed = 32'hBBCC;

    always #10 mclk_in = ~mclk_in;

    mrb_parser_model prs (.mclk_in(mclk_in), .mode_start_out(ms), .store_out(st),
        .serial_out(ser), .limit_out(li), .limit_val_out(lv), .ctrl_out(co),
        .delta_out(dl), .slot_out(sl), .mb_out(mb), .mb_bits_out(f), .code_out(code),
        .len_out(len));

    mrb_ref_buffer uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .multi_ref_selection_mode_start_in(ms), .store_in(st), .picture_serial_in(ser),
        .limit_in(li), .long_term_slot_limit_in(lv), .buffer_control_op_in(co),
        .picture_serial_delta_in(dl), .long_term_slot_in(sl), .mb_in(mb),
        .b_picture_in(f[6]), .fwd_mv_data_in(f[5]), .backward_mv_data_in(f[4]),
        .two_pic_bwd_in(f[3]), .umv_mode_in(f[2]), .prior_five_zero_in(f[1]),
        .fwd_code_in(code), .fwd_code_len_in(len), .backward_ref_select_in(f[0]),
        .forward_ref_present_out(fp), .forward_ref_index_out(fi),
        .fwd_emul_guard_bit_out(fg), .bwd_select_present_out(bp),
        .bwd_emul_guard_bit_out(bg), .fwd_hit_out(fh), .fwd_serial_out(fs),
        .fwd_long_out(fl), .bwd_hit_out(bh), .bwd_serial_out(bs), .loss_out(loss),
        .err_range_out(er), .err_dup_out(ed), .err_missing_out(em), .limit_out(lim),
        .count_out(cnt));

    // ************************************************************
    // compare and verdict
    // ************************************************************
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        check("pending", evq.size() + mbq.size(), 0);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ************************************************************
    // monitor: oldest note against each result
    // ************************************************************
    always @(posedge mclk_in) mb_pipe <= {mb_pipe[0], mb};

    always @(negedge mclk_in) begin
        logic [31:0] e;
        if (!sys_rst_in && |{loss, er, ed, em}) begin
            check("event", {loss, er, ed, em}, evq.size() ? evq.pop_front() : 4'h0);
        end
        if (mb_pipe[1]) begin
            e = mbq.pop_front();
            check("fwd", {fp, fi, fg, fh, fs, fl}, e[17:0]);
            if (e[31]) check("bwd", {bp, bg, bh, bs}, e[30:18]);
        end
    end

    // ************************************************************
    // stimulus helpers
    // ************************************************************
    // events: loss 8, range 4, dup 2, missing 1
    task automatic ev(input int k, input logic [9:0] a, input logic [4:0] b, input logic [3:0] e);
        if (e !== 4'h0) evq.push_back(e);
        prs.pulse(k, a, b);
    endtask : ev

    // buffer here: short 2, short 1022, long 1023 in default order
    function automatic logic [31:0] mb_exp(input logic [6:0] x, input int idx);
        logic [9:0] ord [3] = '{10'h002, 10'h3FE, 10'h3FF};
        int p;
        logic sp;
        p = idx + (x[6] ? (x[3] ? 2 : 1) : 0);
        sp = x[6] & x[4] & x[3];
        return {x[6], sp, sp & ~x[0] & ~x[2] & x[1], x[4], ord[sp & x[0]],
            x[5], x[5] ? idx[3:0] : 4'h0, x[5] && idx == 1 && !x[2], x[5], ord[p], p == 2};
    endfunction : mb_exp

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [31:0] r;
        int idx;
        repeat (2) @(posedge mclk_in);
        @(negedge mclk_in);
        sys_rst_in = 1'b0;
        ev(0, 10'h000, 5'h00, 4'h0);
        check("limit", lim, 5'h00);
        ev(1, 10'h3FE, 5'h00, 4'h0);
        ev(1, 10'h3FF, 5'h00, 4'h0);
        ev(1, 10'h000, 5'h00, 4'h0);
        ev(1, 10'h002, 5'h00, 4'h8);
        check("count", cnt, 4'h4);
        ev(3, 10'h002, 5'h00, 4'h4);
        ev(2, 10'h000, 5'h02, 4'h0);
        check("limit", lim, 5'h02);
        ev(3, 10'h002, 5'h01, 4'h0);
        ev(3, 10'h002, 5'h01, 4'h0);
        ev(3, 10'h002, 5'h00, 4'h2);
        ev(3, 10'h003, 5'h01, 4'h0);
        check("count", cnt, 4'h3);
        ev(3, 10'h005, 5'h00, 4'h1);
        check("limit", lim, 5'h02);
        // random picture kind, motion data, modes and select; index kept inside the set
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            idx = $unsigned(r[15:8]) % (r[4] ? (r[3] ? 1 : 2) : 3);
            mbq.push_back(mb_exp({r[4], r[6] | r[7], r[5], r[3:0]}, idx));
            prs.mb_evt({r[4], r[6] | r[7], r[5], r[3:0]},
                idx == 0 ? 5'h01 : (idx == 1 ? 5'h00 : 5'h02), idx == 0 ? 3'h1 : 3'h3);
        end
        // five-bit code for index three, past the three stored pictures
        mbq.push_back({14'h0000, 1'b1, 4'h3, 2'h0, 11'h000});
        prs.mb_evt(7'h24, 5'h00, 3'h5);
        ev(2, 10'h000, 5'h01, 4'h0);
        check("count", cnt, 4'h2);
        give_verdict();
    end

    // ************************************************************
    // watchdog, far beyond the roughly 150 cycles of the run
    // ************************************************************
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
endmodule : multi_picture_ref_buffer_mgr_bench
